// ===== shared/rsc_map.vh
/*
 reset source capture: register address, field positions, reset values.
 assumes inclusion by bare name from the design files.
*/
`ifndef RSC_MAP_VH
`define RSC_MAP_VH
`define RSC_FLAGS_ADDR 20'hFFFA8
`define RSC_BIT_OPCODE 7
`define RSC_BIT_WDOG 4
`define RSC_BIT_PARITY 2
`define RSC_BIT_ACCESS 1
`define RSC_BIT_SUPPLY 0
`define RSC_FLAGS_RESET 8'h00
`define RSC_FLAGS_MASK 8'h97
`define RSC_PARDIS_RESET 1'b0
`endif

// ===== hdl/rsc_flag_bank.v
/*
 rsc_flag_bank: five sticky reset-cause flags with a registered read port.
 assumes set pulses and the clear strobe are synchronous to clock_i.
*/
`timescale 1ns/1ns
`include "rsc_map.vh"
module rsc_flag_bank (
   // clock and reset
   input wire clock_i,
   input wire reset_i,
   // flag control
   input wire clear_i,
   input wire [7:0] set_i,
   input wire rd_i,
   // state
   output reg [7:0] flags_o,
   output reg [7:0] rd_data_o
);
   always @(posedge clock_i) begin
      if (reset_i) begin
         flags_o <= `RSC_FLAGS_RESET;
         rd_data_o <= 8'h00;
      end else begin
         // read returns pre-clear value; clear lands on the same edge as the read
         if (rd_i)
            rd_data_o <= flags_o & `RSC_FLAGS_MASK;
         // set beats clear; unset flags hold their value only while no clear is applied
         if (clear_i)
            flags_o <= set_i & `RSC_FLAGS_MASK;
         else
            flags_o <= (flags_o | set_i) & `RSC_FLAGS_MASK;
      end
   end
endmodule

// ===== hdl/rsc_reset_source_capture.v
/*
 rsc_reset_source_capture: records the cause of the last internal reset,
 merges the power-on detector into the reset path and serves the flag
 register to the cpu by byte read.
 holds a one-hot power-on hold machine, the parity reset disable bit,
 the set and clear decode for the five cause flags and the read decode;
 the flags themselves and the read register sit in rsc_flag_bank.
 assumes all request inputs are synchronous one-cycle or level signals on
 clock_i and that reset_i is the plain system reset of this logic.
 assumes the supply comparators are already filtered, so a level seen on
 one edge is taken as the real supply state.
*/
// What this block does
// - remember which internal source caused the latest reset request
// - cpu reads the cause register as one whole byte
// - reset pin, power-on reset and a read clear all five flags; a flag set in the same cycle as the read stays set here
// - bit 7 set by illegal opcode reset, else zero
// - no illegal-opcode reset or flag while under emulator control
// - bit 4 set by watchdog reset, else zero
// - bit 2 set by ram parity reset, else zero
// - bit 1 set by forbidden memory access reset, else zero
// - bit 0 set by supply monitor reset, else zero
// - internal resets set only own flag and keep the others
// - every reset returns parity reset disable to zero
// - power-on detector holds reset until supply above rising threshold
// - power-on detector asserts reset while supply below falling threshold
`timescale 1ns/1ns
`include "rsc_map.vh"
module rsc_reset_source_capture (
   // clock and reset
   input wire clock_i,
   input wire reset_i,
   // reset sources
   input wire ext_reset_pin_i,
   input wire supply_above_rising_i,
   input wire supply_below_falling_i,
   input wire illegal_opcode_i,
   input wire emulator_active_i,
   input wire watchdog_timer_req_i,
   input wire parity_error_i,
   input wire forbidden_access_req_i,
   input wire supply_level_monitor_req_i,
   // parity reset disable control
   input wire parity_dis_wr_i,
   input wire parity_dis_data_i,
   // cpu byte read port
   input wire [19:0] addr_i,
   input wire rd_i,
   input wire wr_i,
   input wire [7:0] wr_data_i,
   output wire [7:0] rd_data_o,
   // reset outputs
   output wire internal_reset_o,
   output wire parity_reset_disable_o
);
   // power-on detector states, one-hot
   localparam [1:0] ST_HOLD = 2'h1;
   localparam [1:0] ST_RUN = 2'h2;

   // flag positions inside the cause register
   localparam integer POS_OPCODE = `RSC_BIT_OPCODE;
   localparam integer POS_WDOG = `RSC_BIT_WDOG;
   localparam integer POS_PARITY = `RSC_BIT_PARITY;
   localparam integer POS_ACCESS = `RSC_BIT_ACCESS;
   localparam integer POS_SUPPLY = `RSC_BIT_SUPPLY;

   // power-on hold machine
   reg [1:0] por_state_ff;
   reg [1:0] nxt_por_state;
   reg por_hold;
   // parity reset disable bit
   reg parity_dis_ff;
   reg nxt_parity_dis;
   // flag set lines and read path
   reg [7:0] set_vec;
   wire rd_hit;
   wire flag_clear;
   wire [7:0] rd_raw;
   // reset sources after masking
   wire opcode_rst;
   wire parity_rst;
   wire wdog_req;
   wire access_req;
   wire supply_req;
   wire any_internal;
   wire hard_clear;

   // high when a byte address selects the cause register
   function addr_hits_flags;
      input [19:0] addr;
      begin
         addr_hits_flags = (addr == `RSC_FLAGS_ADDR);
      end
   endfunction

   // moves one request bit to its flag position
   function [7:0] flag_at;
      input req;
      input integer pos;
      begin
         flag_at = {7'h00, req} << pos;
      end
   endfunction

   // power-on detector: hold until above rising, re-enter below falling
   always @* begin
      nxt_por_state = por_state_ff;
      por_hold = 1'b1;
      case (por_state_ff)
         ST_HOLD: begin
            if (supply_above_rising_i & ~supply_below_falling_i) begin
               nxt_por_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (supply_below_falling_i) begin
               nxt_por_state = ST_HOLD;
            end else begin
               por_hold = 1'b0;
            end
         end
         default: begin
            nxt_por_state = ST_HOLD;
         end
      endcase
   end

   // a fresh system reset always starts in the hold state
   always @(posedge clock_i) begin
      if (reset_i) begin
         por_state_ff <= ST_HOLD;
      end else begin
         por_state_ff <= nxt_por_state;
      end
   end

   // opcode trap is masked under emulator control
   assign opcode_rst = illegal_opcode_i & ~emulator_active_i;
   assign parity_rst = parity_error_i & ~parity_dis_ff;
   assign wdog_req = watchdog_timer_req_i;
   assign access_req = forbidden_access_req_i;
   assign supply_req = supply_level_monitor_req_i;

   // any internal source raises the reset without touching other flags
   assign any_internal = opcode_rst |
      wdog_req |
      parity_rst |
      access_req |
      supply_req;
   // pin and power-on resets wipe the flags instead of setting one
   assign hard_clear = ext_reset_pin_i | por_hold;
   assign internal_reset_o = hard_clear | any_internal;

   // every reset re-enables parity error resets
   always @* begin
      nxt_parity_dis = parity_dis_ff;
      if (internal_reset_o) begin
         nxt_parity_dis = `RSC_PARDIS_RESET;
      end else if (parity_dis_wr_i) begin
         nxt_parity_dis = parity_dis_data_i;
      end
   end

   always @(posedge clock_i) begin
      if (reset_i) begin
         parity_dis_ff <= `RSC_PARDIS_RESET;
      end else begin
         parity_dis_ff <= nxt_parity_dis;
      end
   end
   assign parity_reset_disable_o = parity_dis_ff;

   // byte reads at the flag address; writes and wr_data_i are ignored
   assign rd_hit = rd_i & ~wr_i & addr_hits_flags(addr_i);
   // clear at the read edge, so a set in that same cycle is not lost
   assign flag_clear = hard_clear | rd_hit;

   // one set line per source, gated off while a hard clear is active
   always @* begin
      set_vec = 8'h00;
      if (~hard_clear) begin
         set_vec = set_vec |
            flag_at(opcode_rst, POS_OPCODE);
         set_vec = set_vec |
            flag_at(wdog_req, POS_WDOG);
         set_vec = set_vec |
            flag_at(parity_rst, POS_PARITY);
         set_vec = set_vec |
            flag_at(access_req, POS_ACCESS);
         set_vec = set_vec |
            flag_at(supply_req, POS_SUPPLY);
      end
   end

   // sets and clears meet in the flag bank, set winning
   rsc_flag_bank u_flags (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .clear_i(flag_clear),
      .set_i(set_vec),
      .rd_i(rd_hit),
      .flags_o(),
      .rd_data_o(rd_raw)
   );

   // unused bits are forced low on the way out
   assign rd_data_o = rd_raw & `RSC_FLAGS_MASK;
endmodule

// ===== sim/rsc_capture_sva.sv
/* port checker for the capture block.
 assumes a bind from the bench top. */
`timescale 1ns/1ns
module rsc_capture_sva (
   input wire clock_i, input wire reset_i,
   input wire supply_below_falling_i, input wire watchdog_timer_req_i,
   input wire rd_i, input wire wr_i, input wire [19:0] addr_i,
   input wire [7:0] rd_data_o, input wire internal_reset_o,
   input wire parity_reset_disable_o
);
   wire hit = rd_i && !wr_i && addr_i == 20'hFFFA8;
   wire wd = watchdog_timer_req_i;
   wire ir = internal_reset_o;
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   sequence s_set; !ir ##1 wd ##2 hit; endsequence
   sequence s_rd2; (hit && !wd) ##1 !wd ##1 hit; endsequence
   property p_set; s_set |=> rd_data_o[4]; endproperty
   a_set: assert property (p_set) else $error("flag lost");
   property p_clr; s_rd2 |=> !rd_data_o[4]; endproperty
   a_clr: assert property (p_clr) else $error("no clear");
   property p_hold; !hit |=> $stable(rd_data_o); endproperty
   a_hold: assert property (p_hold) else $error("data moved");
   property p_zero; (rd_data_o & 8'h68) == 8'h00; endproperty
   a_zero: assert property (p_zero) else $error("bit set");
   property p_por; disable iff (1'b0) reset_i |=> ir; endproperty
   a_por: assert property (p_por) else $error("no hold");
   property p_low; supply_below_falling_i |-> ir; endproperty
   a_low: assert property (p_low) else $error("no low");
   property p_wdr; wd |-> ir; endproperty
   a_wdr: assert property (p_wdr) else $error("no reset");
   property p_dis; ir |=> !parity_reset_disable_o; endproperty
   a_dis: assert property (p_dis) else $error("dis kept");
endmodule

// ===== sim/rsc_model.sv
/* cpu and reset source model.
 assumes the block samples on the rising edge of clock_i. */
`timescale 1ns/1ns
module rsc_model (
   input wire clock_i, input wire [7:0] rd_data_i,
   output reg [8:0] src_o = 9'h000, output reg [19:0] addr_o = 20'hFFFA8,
   output reg rd_o = 1'b0, output reg wr_o = 1'b0
);
   task pulse(input [8:0] s);
      begin
         @(negedge clock_i) src_o <= s;
         @(negedge clock_i) src_o <= 9'h000;
      end
   endtask
   // whole byte access only, data taken a cycle after the strobe
   task acc(input [19:0] a, input w, output [7:0] d);
      begin
         @(negedge clock_i) {addr_o, wr_o, rd_o} <= {a, w, !w};
         @(negedge clock_i) {wr_o, rd_o} <= 2'b00;
         d = rd_data_i;
      end
   endtask
endmodule

// ===== sim/rsc_reset_source_capture_tb_top.sv
/* bench top for the capture block.
 assumes model and checker are compiled before it. */
`timescale 1ns/1ns
module rsc_reset_source_capture_tb_top;
   reg clock_i = 1'b0, reset_i = 1'b1, lo = 1'b0, above = 1'b1;
   reg [7:0] wbus = 8'h00;
   wire [8:0] s;
   wire [19:0] a;
   wire rd, wr, ir, pd;
   wire [7:0] q;
   reg [7:0] d;
   reg [44:0] srcs = {9'h040, 9'h020, 9'h010, 9'h008, 9'h002};
   reg [39:0] exps = 40'h0102041080;
   integer err_total = 0, n_compared = 0, i;
   always #10 clock_i = ~clock_i;
   rsc_model u_rsc_model (.clock_i(clock_i), .rd_data_i(q), .src_o(s),
      .addr_o(a), .rd_o(rd), .wr_o(wr));
   rsc_reset_source_capture u_rsc_reset_source_capture (.clock_i(clock_i),
      .reset_i(reset_i), .ext_reset_pin_i(s[0]),
      .supply_above_rising_i(above), .supply_below_falling_i(lo),
      .illegal_opcode_i(s[1]), .emulator_active_i(s[2]),
      .watchdog_timer_req_i(s[3]), .parity_error_i(s[4]),
      .forbidden_access_req_i(s[5]), .supply_level_monitor_req_i(s[6]),
      .parity_dis_wr_i(s[7]), .parity_dis_data_i(s[8]), .addr_i(a),
      .rd_i(rd), .wr_i(wr), .wr_data_i(wbus), .rd_data_o(q),
      .internal_reset_o(ir), .parity_reset_disable_o(pd));
   task chk(input [31:0] n, input [7:0] v, input [7:0] e);
      begin
         n_compared = n_compared + 1;
         if (v !== e) begin
            err_total = err_total + 1;
            $display("unexpected %0s exp %h seen %h", n, e, v);
         end
      end
   endtask
   task rc(input [7:0] e);
      begin
         u_rsc_model.acc(20'hFFFA8, 1'b0, d);
         chk("flag", d, e);
      end
   endtask
   task close_out;
      begin
         if (err_total == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   initial begin
      #100000 err_total = err_total + 1;
      close_out;
   end
   initial begin
      repeat (2) @(negedge clock_i);
      reset_i = 1'b0;
      rc(8'h00);
      for (i = 0; i < 5; i = i + 1) begin
         u_rsc_model.pulse(srcs[i*9 +: 9]);
         rc(exps[i*8 +: 8]);
         rc(8'h00);
      end
      u_rsc_model.pulse(9'h008);
      u_rsc_model.pulse(9'h040);
      rc(8'h11);
      u_rsc_model.pulse(9'h006);
      u_rsc_model.pulse(9'h008);
      wbus = 8'hFF;
      u_rsc_model.acc(20'hFFFA8, 1'b1, d);
      chk("wr", d, 8'h11);
      u_rsc_model.acc(20'hFFFA9, 1'b0, d);
      chk("miss", d, 8'h11);
      rc(8'h10);
      u_rsc_model.pulse(9'h180);
      chk("pdis", {7'h00, pd}, 8'h01);
      u_rsc_model.pulse(9'h018);
      chk("pdis", {7'h00, pd}, 8'h00);
      rc(8'h10);
      u_rsc_model.pulse(9'h008);
      u_rsc_model.pulse(9'h001);
      rc(8'h00);
      u_rsc_model.pulse(9'h008);
      lo = 1'b1;
      above = 1'b0;
      @(negedge clock_i) chk("irst", {7'h00, ir}, 8'h01);
      lo = 1'b0;
      @(negedge clock_i) chk("hold", {7'h00, ir}, 8'h01);
      above = 1'b1;
      @(negedge clock_i) chk("free", {7'h00, ir}, 8'h00);
      rc(8'h00);
      close_out;
   end
endmodule
bind rsc_reset_source_capture rsc_capture_sva u_rsc_capture_sva (
   .clock_i(clock_i), .reset_i(reset_i),
   .supply_below_falling_i(supply_below_falling_i),
   .watchdog_timer_req_i(watchdog_timer_req_i), .rd_i(rd_i), .wr_i(wr_i),
   .addr_i(addr_i), .rd_data_o(rd_data_o),
   .internal_reset_o(internal_reset_o),
   .parity_reset_disable_o(parity_reset_disable_o));
